// file: adc_cmd_map.svh
/*
   Holds the bit positions, reset values, pin indexes, fixed channel numbers,
   table values and timing constants of the ADC command decoder.
   Assumes it is included by bare name; it defines macros only.
*/
`ifndef ADC_CMD_MAP_SVH
`define ADC_CMD_MAP_SVH

// ====================================================================
// command byte routing and fields
`define CONV_SEL_BIT   7
`define SETUP_SEL_BIT  6
`define AVG_SEL_BIT    5
`define RST_SEL_BIT    4
`define RST_FIFO_BIT   3
`define RST_KEEP_MASK  8'hF8
`define CH_HI          6
`define CH_LO          3
`define SCAN_HI        2
`define SCAN_LO        1
`define TEMP_BIT       0
`define CKM_HI         5
`define CKM_LO         4
`define REFM_HI        3
`define REFM_LO        2
`define PADR_HI        1
`define PADR_LO        0
`define AVERAGING_ENABLE_BIT      4
`define NAVG_HI        3
`define NAVG_LO        2
`define NSCAN_HI       1
`define NSCAN_LO       0

// ====================================================================
// codes and reset values
`define REG_RESET      8'h00
`define SETUP_RESET    8'h20
`define CKM_EXT        2'h3
`define SCAN_LOW_UP    2'h0
`define SCAN_REPEAT    2'h2
`define SCAN_ONCE      2'h3
`define REFM_INT_OFF   2'h0
`define REFM_INT_ON    2'h2
`define REFM_EXT_DIFF  2'h3
`define PADR_UNI       2'h2
`define CHANNELS       16
`define PAIRS          8
`define CONVERSION_START_PIN_CH       4'hF
`define REFN_CH        4'hE
`define ONE_SAMPLE     6'h01
`define NAVG_0         6'h04
`define NAVG_1         6'h08
`define NAVG_2         6'h10
`define NAVG_3         6'h20
`define NSCAN_0        5'h04
`define NSCAN_1        5'h08
`define NSCAN_2        5'h0C
`define NSCAN_3        5'h10

// ====================================================================
// serial port
`define PIN_SCLK       0
`define PIN_CS         1
`define PIN_DIN        2
`define PIN_CNV        3
`define PIN_IDLE       4'hA
`define BYTE_LAST      3'h7
`define WORD_LAST      4'hF
`define LEAD_ZEROS     4'h0

// ====================================================================
// timing
`define CORE_CLK_NS    100
`define T_CNV_NS       3500
`define T_TS_NS        65000
`define T_RP_NS        65000
`define CYC_CEIL(ns)   (((ns) + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define T_CNV_CYC      `CYC_CEIL(`T_CNV_NS)
`define T_TS_CYC       `CYC_CEIL(`T_TS_NS)
`define T_RP_CYC       `CYC_CEIL(`T_RP_NS)

`endif

// file: adc_cmd_pkg.sv
/*
   Holds the types of the ADC command decoder: decode states and the
   state records of the serial port and of the decoder core.
   Assumes nothing of its surroundings.
*/
package adc_cmd_pkg;

   typedef enum logic [2:0] {
      DEC_CMD = 3'b001,
      DEC_UNI = 3'b010,
      DEC_BIP = 3'b100
   } decode_state_t;

   typedef struct packed {
      logic [3:0]  s1, s2, s3, lvl;
      logic        seen_rise;
      logic [7:0]  shift_in;
      logic [2:0]  bit_cnt;
      logic [15:0] out_sh;
      logic [3:0]  out_cnt;
      logic        dout;
      logic        byte_valid;
      logic [7:0]  byte_data;
      logic        frame_start, frame_end, conversion_start_pin_fall, pop;
   } port_state_t;

   typedef struct packed {
      decode_state_t dec;
      logic [7:0]    conv, setup, avg, rst, uni, bip;
      logic          ref_powered;
      logic          scan_start, fifo_clear, temp_request, reference_wake, result_pop;
      logic [15:0]   chan_mask;
      logic [7:0]    bip_mask;
      logic [4:0]    result_count;
      logic [5:0]    samples;
      logic [19:0]   scan_time;
   } core_state_t;

endpackage

// file: spi_link_if.sv
/*
   Carries received bytes, frame events and result pops from the serial
   port to the decoder core. Assumes both ends run on core_clk.
*/
`timescale 1ns/1ps
interface spi_link_if (
   input wire logic core_clk
);
   logic       byte_valid;
   logic [7:0] byte_data;
   logic       frame_start;
   logic       frame_end;
   logic       conversion_start_pin_fall;
   logic       pop;

   modport port (output byte_valid, byte_data, frame_start, frame_end, conversion_start_pin_fall, pop);
   modport core (input  byte_valid, byte_data, frame_start, frame_end, conversion_start_pin_fall, pop);
endinterface

// file: spi_byte_port.sv
/*
   Serial port of the ADC: filters the pins, assembles command bytes on
   rising serial clock edges and shifts 16-bit results out on falling ones.
   Assumes pins are asynchronous to core_clk and the serial clock is slow
   enough to give several core cycles per phase.
*/
`timescale 1ns/1ps
`include "adc_cmd_map.svh"
module spi_byte_port (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        din,
   input  wire logic        conversion_start_pin_n,
   input  wire logic [11:0] result_word,
   input  wire logic        result_valid,
   output logic             dout,
   spi_link_if.port         lk
);
   adc_cmd_pkg::port_state_t st;
   adc_cmd_pkg::port_state_t next_st;
   logic [3:0]  lvl_n;
   logic        sclk_rise, sclk_fall, cs_fall, cs_rise;
   logic [15:0] word_in;

   // ====================================================================
   // pin filter: a change counts once stages two and three agree
   assign lvl_n     = (st.s3 & ~(st.s2 ^ st.s3)) | (st.lvl & (st.s2 ^ st.s3));
   assign sclk_rise = ~st.lvl[`PIN_SCLK] & lvl_n[`PIN_SCLK];
   assign sclk_fall = st.lvl[`PIN_SCLK] & ~lvl_n[`PIN_SCLK];
   assign cs_fall   = st.lvl[`PIN_CS] & ~lvl_n[`PIN_CS];
   assign cs_rise   = ~st.lvl[`PIN_CS] & lvl_n[`PIN_CS];
   assign word_in   = result_valid ? {`LEAD_ZEROS, result_word} : '0;

   // ====================================================================
   // byte assembly and result shifting
   always_comb begin
      next_st            = st;
      next_st.s1         = {conversion_start_pin_n, din, cs_n, sclk};
      next_st.s2         = st.s1;
      next_st.s3         = st.s2;
      next_st.lvl        = lvl_n;
      next_st.byte_valid = 1'h0;
      next_st.frame_start = 1'h0;
      next_st.frame_end  = 1'h0;
      next_st.pop        = 1'h0;
      next_st.conversion_start_pin_fall = st.lvl[`PIN_CNV] & ~lvl_n[`PIN_CNV];
      if (cs_fall) begin
         next_st.frame_start = 1'h1;
         next_st.bit_cnt     = '0;
         next_st.out_cnt     = '0;
         next_st.seen_rise   = 1'h0;
         next_st.out_sh      = word_in;
         next_st.pop         = result_valid;
         next_st.dout        = word_in[15];
      end else if (cs_rise) begin
         next_st.frame_end = 1'h1;
         next_st.dout      = 1'h0;
      end else if (!st.lvl[`PIN_CS]) begin
         if (sclk_rise) begin
            next_st.seen_rise = 1'h1;
            next_st.shift_in  = {st.shift_in[6:0], st.lvl[`PIN_DIN]};
            next_st.bit_cnt   = st.bit_cnt + 3'h1;
            if (st.bit_cnt == `BYTE_LAST) begin
               next_st.byte_valid = 1'h1;
               next_st.byte_data  = {st.shift_in[6:0], st.lvl[`PIN_DIN]};
            end
         end
         // idle-high clock: the fall before the first rise moves nothing
         if (sclk_fall && st.seen_rise) begin
            next_st.out_cnt = st.out_cnt + 4'h1;
            if (st.out_cnt == `WORD_LAST) begin
               next_st.out_sh = word_in;
               next_st.pop    = result_valid;
            end else begin
               next_st.out_sh = {st.out_sh[14:0], 1'h0};
            end
            next_st.dout = next_st.out_sh[15];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st     <= '0;
         st.s1  <= `PIN_IDLE;
         st.s2  <= `PIN_IDLE;
         st.s3  <= `PIN_IDLE;
         st.lvl <= `PIN_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign dout           = st.dout;
   assign lk.byte_valid  = st.byte_valid;
   assign lk.byte_data   = st.byte_data;
   assign lk.frame_start = st.frame_start;
   assign lk.frame_end   = st.frame_end;
   assign lk.conversion_start_pin_fall  = st.conversion_start_pin_fall;
   assign lk.pop         = st.pop;

   dout_edge_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      $changed(st.dout) |-> $past(st.lvl[`PIN_SCLK]) && !st.lvl[`PIN_SCLK]
                            || $past(st.lvl[`PIN_CS]) != st.lvl[`PIN_CS])
      else $error("data output moved away from a falling clock edge");
endmodule

// file: adc_cmd_decoder.sv
/*
   Command decoder of a 16-channel 12-bit ADC. Takes command bytes from the
   serial port, keeps the conversion, setup, averaging, reset and pair
   registers, and plans each scan: channels, result count, samples per
   result and, for clock modes 00 and 10, the expected scan time.
   Assumes a conversion core that runs the plan and a result FIFO that
   presents its oldest word on result_word while result_valid is high.
*/
`timescale 1ns/1ps
`include "adc_cmd_map.svh"
module adc_cmd_decoder (
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        din,
   input  wire logic        conversion_start_pin_n,
   input  wire logic [11:0] result_word,
   input  wire logic        result_valid,
   output logic             dout,
   output logic             result_pop,
   output logic [7:0]       conversion_request,
   output logic [7:0]       setup_config,
   output logic [7:0]       averaging_config,
   output logic [7:0]       soft_reset_command,
   output logic [7:0]       unipolar_pair_enable,
   output logic [7:0]       bipolar_pair_enable,
   output logic [7:0]       bipolar_pair_mask,
   output logic             scan_start,
   output logic [15:0]      scan_channel_mask,
   output logic [4:0]       result_count,
   output logic [5:0]       samples_per_result,
   output logic             temp_request,
   output logic             reference_wake,
   output logic [19:0]      scan_time_cycles,
   output logic             fifo_clear
);
   adc_cmd_pkg::core_state_t st;
   adc_cmd_pkg::core_state_t next_st;
   logic [7:0]  d;
   logic        cmd_byte, conv_write, setup_write, avg_write, rst_write, start_now;
   logic [7:0]  req_conv;
   logic [3:0]  req_ch;
   logic [1:0]  req_scan;
   logic [1:0]  clk_mode;
   logic        single, ref_diff, avg_on, wake;
   logic [15:0] blk, in_rng, chan_mask;
   logic [4:0]  plan_count;
   logic [5:0]  plan_samples;
   logic [19:0] plan_time;

   spi_link_if lk (.core_clk(core_clk));

   spi_byte_port u_port (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .sclk         (sclk),
      .cs_n         (cs_n),
      .din          (din),
      .conversion_start_pin_n      (conversion_start_pin_n),
      .result_word  (result_word),
      .result_valid (result_valid),
      .dout         (dout),
      .lk           (lk.port)
   );

   function automatic logic [4:0] count_ones(input logic [15:0] v);
      logic [4:0] c;
      c = 5'h00;
      for (int k = 0; k < `CHANNELS; k++) begin
         c = c + 5'(v[k]);
      end
      return c;
   endfunction

   // ====================================================================
   // byte routing
   assign d           = lk.byte_data;
   assign cmd_byte    = lk.byte_valid && st.dec == adc_cmd_pkg::DEC_CMD;
   assign conv_write  = cmd_byte && d[`CONV_SEL_BIT];
   assign setup_write = cmd_byte && !d[`CONV_SEL_BIT] && d[`SETUP_SEL_BIT];
   assign avg_write   = cmd_byte && d[`CONV_SEL_BIT:`SETUP_SEL_BIT] == 2'h0 && d[`AVG_SEL_BIT];
   assign rst_write   = cmd_byte && d[`CONV_SEL_BIT:`AVG_SEL_BIT] == 3'h0 && d[`RST_SEL_BIT];
   assign clk_mode    = st.setup[`CKM_HI:`CKM_LO];
   assign start_now   = (conv_write && clk_mode[1]) || (lk.conversion_start_pin_fall && !clk_mode[1]);

   // ====================================================================
   // scan plan
   assign req_conv = conv_write ? d : st.conv;
   assign req_ch   = req_conv[`CH_HI:`CH_LO];
   assign req_scan = req_conv[`SCAN_HI:`SCAN_LO];
   // external clock mode disables scanning
   assign single   = req_scan[1] || clk_mode == `CKM_EXT;
   assign ref_diff = st.setup[`REFM_HI:`REFM_LO] == `REFM_EXT_DIFF;

   for (genvar i = 0; i < `CHANNELS; i++) begin : g_chan
      localparam logic [3:0] CH = 4'(i);
      logic pdiff;
      assign pdiff = st.uni[`PAIRS - 1 - i / 2] | st.bip[`PAIRS - 1 - i / 2];
      assign blk[i] = (CH == `CONVERSION_START_PIN_CH && !clk_mode[1]) || (CH == `REFN_CH && ref_diff);
      assign in_rng[i] = single ? CH == req_ch
                       : (req_scan == `SCAN_LOW_UP ? CH <= req_ch : CH >= req_ch);
      assign chan_mask[i] = in_rng[i] & ~blk[i]
                          & (CH[0] ? ~pdiff : ~(pdiff & blk[i ^ 1]));
   end

   assign avg_on = st.avg[`AVERAGING_ENABLE_BIT] && clk_mode != `CKM_EXT;

   always_comb begin
      plan_count = count_ones(chan_mask);
      if (req_scan == `SCAN_REPEAT && clk_mode != `CKM_EXT && plan_count != 5'h00) begin
         case (st.avg[`NSCAN_HI:`NSCAN_LO])
            2'h0:    plan_count = `NSCAN_0;
            2'h1:    plan_count = `NSCAN_1;
            2'h2:    plan_count = `NSCAN_2;
            default: plan_count = `NSCAN_3;
         endcase
      end
      plan_samples = `ONE_SAMPLE;
      if (avg_on) begin
         case (st.avg[`NAVG_HI:`NAVG_LO])
            2'h0:    plan_samples = `NAVG_0;
            2'h1:    plan_samples = `NAVG_1;
            2'h2:    plan_samples = `NAVG_2;
            default: plan_samples = `NAVG_3;
         endcase
      end
   end

   assign wake = st.setup[`REFM_HI:`REFM_LO] == `REFM_INT_OFF
              || (st.setup[`REFM_HI:`REFM_LO] == `REFM_INT_ON && !st.ref_powered);

   always_comb begin
      plan_time = 20'h00000;
      if (!clk_mode[0]) begin
         plan_time = 20'(`T_CNV_CYC) * 20'(plan_samples) * 20'(plan_count)
                   + (req_conv[`TEMP_BIT] ? 20'(`T_TS_CYC) : 20'h00000)
                   + (wake ? 20'(`T_RP_CYC) : 20'h00000);
      end
   end

   // ====================================================================
   // register file and decode state
   always_comb begin
      next_st            = st;
      next_st.scan_start = 1'h0;
      next_st.fifo_clear = 1'h0;
      next_st.result_pop = lk.pop;
      if (lk.byte_valid) begin
         case (st.dec)
            adc_cmd_pkg::DEC_UNI: begin
               next_st.uni = d;
               next_st.dec = adc_cmd_pkg::DEC_CMD;
            end
            adc_cmd_pkg::DEC_BIP: begin
               next_st.bip = d;
               next_st.dec = adc_cmd_pkg::DEC_CMD;
            end
            adc_cmd_pkg::DEC_CMD: begin
               if (conv_write) begin
                  next_st.conv = d;
               end else if (setup_write) begin
                  next_st.setup = d;
                  if (d[`PADR_HI]) begin
                     next_st.dec = d[`PADR_LO] ? adc_cmd_pkg::DEC_BIP : adc_cmd_pkg::DEC_UNI;
                  end
               end else if (avg_write) begin
                  next_st.avg = d;
               end else if (rst_write) begin
                  next_st.rst        = d & `RST_KEEP_MASK;
                  next_st.fifo_clear = 1'h1;
                  if (!d[`RST_FIFO_BIT]) begin
                     next_st.conv        = `REG_RESET;
                     next_st.setup       = `SETUP_RESET;
                     next_st.avg         = `REG_RESET;
                     next_st.rst         = `REG_RESET;
                     next_st.uni         = `REG_RESET;
                     next_st.bip         = `REG_RESET;
                     next_st.ref_powered = 1'h0;
                  end
               end
            end
            default: next_st.dec = adc_cmd_pkg::DEC_CMD;
         endcase
      end
      if (lk.frame_end) begin
         next_st.dec = adc_cmd_pkg::DEC_CMD;
      end
      if (start_now) begin
         next_st.scan_start     = 1'h1;
         next_st.chan_mask      = chan_mask;
         next_st.result_count   = plan_count + 5'(req_conv[`TEMP_BIT]);
         next_st.samples        = plan_samples;
         next_st.temp_request   = req_conv[`TEMP_BIT];
         next_st.reference_wake = wake;
         next_st.scan_time      = plan_time;
         next_st.ref_powered    = st.setup[`REFM_HI:`REFM_LO] == `REFM_INT_ON;
      end
      next_st.bip_mask = next_st.bip & ~next_st.uni;
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         st       <= '0;
         st.dec   <= adc_cmd_pkg::DEC_CMD;
         st.setup <= `SETUP_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ====================================================================
   // outputs
   assign result_pop           = st.result_pop;
   assign conversion_request   = st.conv;
   assign setup_config         = st.setup;
   assign averaging_config     = st.avg;
   assign soft_reset_command   = st.rst;
   assign unipolar_pair_enable = st.uni;
   assign bipolar_pair_enable  = st.bip;
   assign bipolar_pair_mask    = st.bip_mask;
   assign scan_start           = st.scan_start;
   assign scan_channel_mask    = st.chan_mask;
   assign result_count         = st.result_count;
   assign samples_per_result   = st.samples;
   assign temp_request         = st.temp_request;
   assign reference_wake       = st.reference_wake;
   assign scan_time_cycles     = st.scan_time;
   assign fifo_clear           = st.fifo_clear;

   // ====================================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   conv_start_a: assert property (conv_write && clk_mode[1] |=> st.scan_start)
      else $error("conversion byte did not start a scan");
   pin_start_a: assert property (lk.conversion_start_pin_fall && !clk_mode[1] |=> st.scan_start)
      else $error("start pin pulse did not start a scan");
   conv_store_a: assert property (conv_write |=> st.conv == $past(d))
      else $error("conversion byte not stored");
   pair_route_a: assert property (setup_write && d[`PADR_HI:`PADR_LO] == `PADR_UNI
      |=> st.dec == adc_cmd_pkg::DEC_UNI)
      else $error("unipolar address did not arm the pair write");
   pair_write_a: assert property (st.dec == adc_cmd_pkg::DEC_BIP && lk.byte_valid
      |=> st.bip == $past(d) && st.dec == adc_cmd_pkg::DEC_CMD)
      else $error("bipolar pair byte not written");
   pair_skip_a: assert property (setup_write && !d[`PADR_HI]
      |=> st.dec == adc_cmd_pkg::DEC_CMD && $stable(st.uni) && $stable(st.bip))
      else $error("pair register touched without address");
   fifo_clear_a: assert property (rst_write && d[`RST_FIFO_BIT]
      |=> st.fifo_clear && $stable(st.setup) ##1 !st.fifo_clear)
      else $error("fifo clear not a single pulse");
   soft_reset_a: assert property (rst_write && !d[`RST_FIFO_BIT]
      |=> st.setup == `SETUP_RESET && st.avg == `REG_RESET && st.uni == `REG_RESET)
      else $error("full reset did not restore defaults");
   unipolar_wins_a: assert property ((st.bip_mask & st.uni) == 8'h00)
      else $error("pair both unipolar and bipolar");
   avg_off_a: assert property (st.scan_start && clk_mode == `CKM_EXT
      |-> st.samples == `ONE_SAMPLE)
      else $error("averaging used in external clock mode");
   once_a: assert property (start_now && req_scan == `SCAN_ONCE
      |=> st.result_count <= 5'(st.temp_request) + 5'h01)
      else $error("single conversion planned more than one result");
endmodule

// file: spi_host_model.sv
/*
   Serial host model: drives chip select, serial clock and data in, mode 0.
   Assumes its tasks are called just after a rising core_clk edge.
*/
`timescale 1ns/1ps
module spi_host_model (
   input  wire logic core_clk,
   input  wire logic dout,
   output logic      sclk,
   output logic      cs_n,
   output logic      din,
   output logic      conversion_start_pin_n
);
   // ==========================================================
   // idle levels
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din = 1'b0;
      conversion_start_pin_n = 1'b1;
   end

   // ==========================================================
   // one frame, 800 ns serial clock period; callers name lower pair channels only
   // data out read at the end of each high phase: the port's filter delays it
   task automatic xfer(input logic [15:0] data, input int nbits,
                       output logic [15:0] rx);
      rx = 16'h0000;
      cs_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      for (int i = nbits - 1; i >= 0; i--) begin
         din <= data[i];
         repeat (4) @(posedge core_clk);
         sclk <= 1'b1;
         repeat (4) @(posedge core_clk);
         rx = {rx[14:0], dout};
         sclk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b1;
      din <= ~din;
      repeat (4) @(posedge core_clk);
   endtask

   // ==========================================================
   // start pin pulse, low for eight core cycles
   task automatic start_pulse;
      conversion_start_pin_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      conversion_start_pin_n <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask
endmodule

// file: adc_command_register_decoder_tb_top.sv
/*
   Testbench of the command decoder: frames of command bytes, then register checks.
   Assumes the host model and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "adc_cmd_map.svh"
module adc_command_register_decoder_tb_top;
   logic        core_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        sclk, cs_n, din, conversion_start_pin_n, dout, result_pop, scan_start;
   logic        temp_request, reference_wake, fifo_clear;
   logic        saw_clear = 1'b0;
   logic        saw_scan = 1'b0;
   logic        clr_saw = 1'b0;
   logic [3:0]  n_pop = 4'h0;
   logic [15:0] rx_word;
   logic [11:0] result_word = 12'hABC;
   logic        result_valid = 1'b0;
   logic [7:0]  conversion_request, setup_config, averaging_config, soft_reset_command;
   logic [7:0]  unipolar_pair_enable, bipolar_pair_enable, bipolar_pair_mask;
   logic [15:0] scan_channel_mask;
   logic [4:0]  result_count;
   logic [5:0]  samples_per_result;
   logic [19:0] scan_time_cycles;
   int          num_errors = 0;
   int          n_compared = 0;

   always #50 core_clk = ~core_clk;

   spi_host_model spi_host_model_i (.core_clk, .dout, .sclk, .cs_n, .din, .conversion_start_pin_n);

   adc_cmd_decoder adc_cmd_decoder_i (.core_clk, .reset_n, .sclk, .cs_n, .din, .conversion_start_pin_n,
      .result_word, .result_valid, .dout, .result_pop, .conversion_request, .setup_config,
      .averaging_config, .soft_reset_command, .unipolar_pair_enable, .bipolar_pair_enable,
      .bipolar_pair_mask, .scan_start, .scan_channel_mask, .result_count, .samples_per_result,
      .temp_request, .reference_wake, .scan_time_cycles, .fifo_clear);

   // ==========================================================
   // pulse catchers
   always @(posedge core_clk) begin
      if (clr_saw) begin
         saw_clear <= 1'b0;
         saw_scan <= 1'b0;
         n_pop <= 4'h0;
      end else begin
         if (fifo_clear === 1'b1)
            saw_clear <= 1'b1;
         if (scan_start === 1'b1)
            saw_scan <= 1'b1;
         if (result_pop === 1'b1)
            n_pop <= n_pop + 4'h1;
      end
   end

   // ==========================================================
   // helpers
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // n of zero pulses the start pin instead of sending a frame
   task automatic send(input logic [15:0] d, input int n);
      clr_saw <= 1'b1;
      @(posedge core_clk);
      clr_saw <= 1'b0;
      if (n == 0)
         spi_host_model_i.start_pulse();
      else
         spi_host_model_i.xfer(d, n, rx_word);
      repeat (2) @(posedge core_clk);
   endtask

   task automatic test_done;
      $display("Errors %0d, comparisons %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      test_done;
   end

   // ==========================================================
   // scenarios
   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      check(setup_config, 20'h20);
      check({averaging_config, unipolar_pair_enable}, 20'h0);
      result_valid <= 1'b1;
      send(16'h0000, 16);
      result_valid <= 1'b0;
      check(rx_word, 20'h00ABC);
      check(n_pop, 20'h2);
      send(16'h0086, 8);
      check(conversion_request, 20'h86);
      check({scan_channel_mask, 3'h0, saw_scan}, 20'h00011);
      check(result_count, 20'h1);
      send(16'h4A80, 16);
      check({setup_config, unipolar_pair_enable}, 20'h4A80);
      send(16'h4B81, 16);
      check({bipolar_pair_enable, bipolar_pair_mask}, 20'h8101);
      send(16'h0000, 0);
      check({scan_channel_mask, 3'h0, saw_scan}, 20'h00011);
      check(scan_time_cycles, 20'(`T_CNV_CYC + `T_RP_CYC));
      check(reference_wake, 20'h1);
      send(16'h68A1, 16);
      check({unipolar_pair_enable, conversion_request}, 20'h80A1);
      check({scan_channel_mask, 3'h0, temp_request}, 20'h001D1);
      check(result_count, 20'h5);
      check(scan_time_cycles, 20'(4 * `T_CNV_CYC + `T_TS_CYC));
      check(reference_wake, 20'h0);
      send(16'h3DA4, 16);
      check({averaging_config, 3'h0, result_count}, 20'h3D08);
      check(samples_per_result, 20'h20);
      check(scan_time_cycles, 20'(32 * 8 * `T_CNV_CYC));
      send(16'h7886, 16);
      check(samples_per_result, 20'h1);
      check(scan_time_cycles, 20'h0);
      send(16'h001F, 8);
      check({soft_reset_command, setup_config, 3'h0, saw_clear}, 20'h18781);
      send(16'h0010, 8);
      check({setup_config, 3'h0, saw_clear}, 20'h201);
      check({unipolar_pair_enable, bipolar_pair_enable}, 20'h0);
      test_done;
   end
endmodule
